/* design/mcd_core.sv */
/*
 * Instruction decode and execute for an 8-bit core with 13-bit
 * instruction words, including data registers, status, page/bank
 * selects, control registers and the return stack.
 * Assumes program memory answers an address with the word on the
 * next clock, and that the jump cycle option is stable after reset.
 */
`timescale 1ns/1ps
`include "mcd_cfg.svh"
// Behaviour
// - Decode each 13-bit word into opcode and operands
// - One instruction cycle is two oscillator periods
// - Writes to program counter take two cycles
// - Jump, call: two when option bit set; return literal, taken skip: two
// - Bit clear, set and skip on any register
// - I/O registers behave as general registers
// - Sleep and watchdog clear update T and P
// - Move accumulator to and from control registers
// - Enable, disable interrupts; return from interrupt enables them
// - Call pushes next address, jumps within page
// - Jump loads page and literal, no push
// - Return literal loads accumulator and pops
// - Decrement skip if zero, flags untouched
// - Increment skip if zero, flags untouched
// - Rotate through carry, either direction
// - Nibble swap, flags untouched
// - Page and bank select load their fields
// - Literal ops with specified flag updates
// - Option bit chooses one or two jump cycles
module mcd_core
	import mcd_pkg::*;
(
	input  wire logic               i_clk_sys,
	input  wire logic               i_rst,
	input  wire logic [`MCD_IW-1:0] i_instr,
	input  wire logic               i_jump_cycle_select,
	input  wire logic [7:0]         i_io_rd,
	output logic [`MCD_PCW-1:0]     o_pc,
	output logic                    o_phase,
	output mcd_regwr_s              o_io_wr,
	output logic [7:0]              o_acc,
	output logic [7:0]              o_status,
	output logic                    o_irq_en,
	output logic                    o_wdt_clr,
	output logic                    o_osc_stop,
	output logic [3:0]              o_cr_addr,
	output logic [7:0]              o_cr_wdata,
	output logic                    o_cr_wr
);
	mcd_state_e          state_ff, nxt_state;
	logic                phase_ff;
	logic [`MCD_PCW-1:0] pc_ff;
	logic [`MCD_PCW-1:0] nxt_pc;
	logic [7:0]          acc_ff, nxt_acc;
	logic [7:0]          stat_ff, nxt_stat;
	logic [7:0]          bank_ff, nxt_bank;
	logic [1:0]          page_ff, nxt_page;
	logic [7:0]          regs_ff [64];
	logic [7:0]          cregs_ff [16];
	logic                irq_en_ff, nxt_irq_en;
	logic                wdt_clr_ff, osc_stop_ff;
	logic                jsel_ff;
	logic                cr_wr_ff;
	logic [3:0]          cr_addr_ff;
	logic [7:0]          cr_wdata_ff;
	mcd_regwr_s          io_wr_ff;
	mcd_regwr_s          rw;
	logic                nxt_skip, nxt_redirect, nxt_wdc, nxt_sleep;
	logic                push, pop;
	logic                crw;
	logic [3:0]          cra;
	logic [`MCD_PCW-1:0] stk_top;
	logic [`MCD_PCW-1:0] pc_inc;
	mcd_alu_s            alu;
	logic [7:0]          alu_a, alu_b;
	logic                alu_sub;
	logic [7:0]          rval, res;
	logic [5:0]          ra;
	logic                dst_r;
	logic [2:0]          bidx;
	logic [3:0]          lop;
	logic                exec;

	// Operand fields of the current word
	assign ra     = i_instr[5:0];
	assign dst_r  = i_instr[6];
	assign bidx   = i_instr[8:6];
	assign lop    = i_instr[11:8];
	assign pc_inc = pc_ff + `MCD_PCW'(1);
	// Execute once per instruction cycle, on its second half
	assign exec   = phase_ff && (state_ff == MCD_RUN);

	// Register read: special registers are mapped into the data space
	always_comb begin
		case (ra)
			`MCD_ADDR_PC:   rval = pc_ff[7:0];
			`MCD_ADDR_STAT: rval = stat_ff;
			`MCD_ADDR_BANK: rval = bank_ff;
			`MCD_ADDR_PAGE: rval = {6'h00, page_ff};
			default:        rval = regs_ff[ra];
		endcase
	end

	// Shared adder serves register and literal arithmetic
	always_comb begin
		alu_a   = rval;
		alu_b   = acc_ff;
		alu_sub = 1'b0;
		if (i_instr[12]) begin
			alu_a = i_instr[7:0];
		end
		if (i_instr[12:8] == 5'h01 || lop == `MCD_LIT_SUB && i_instr[12]) begin
			alu_sub = 1'b1;
		end
	end

	mcd_alu u_alu (
		.i_a   (alu_a),
		.i_b   (alu_b),
		.i_sub (alu_sub),
		.o_res (alu)
	);

	mcd_stack u_stack (
		.i_clk_sys (i_clk_sys),
		.i_rst     (i_rst),
		.i_push    (push),
		.i_pop     (pop),
		.i_data    (pc_inc),
		.o_top     (stk_top)
	);

	// Decode and execute; nothing is committed unless exec is high
	always_comb begin
		nxt_pc      = pc_inc;
		nxt_acc     = acc_ff;
		nxt_stat    = stat_ff;
		nxt_bank    = bank_ff;
		nxt_page    = page_ff;
		nxt_irq_en  = irq_en_ff;
		nxt_skip    = 1'b0;
		nxt_redirect = 1'b0;
		nxt_wdc     = 1'b0;
		nxt_sleep   = 1'b0;
		push        = 1'b0;
		pop         = 1'b0;
		crw         = 1'b0;
		cra         = i_instr[3:0];
		rw          = '{wr: 1'b0, addr: ra, data: 8'h00};
		res         = 8'h00;
		if (i_instr[12]) begin
			if (i_instr[11:10] == 2'b00 || i_instr[11:10] == 2'b01) begin
				// Call and jump share the in-page target
				nxt_pc = {page_ff, i_instr[9:0]};
				nxt_redirect = jsel_ff;
				push = ~i_instr[10];
			end else begin
				case (lop)
					`MCD_LIT_MOV: nxt_acc = i_instr[7:0];
					`MCD_LIT_OR: begin
						nxt_acc = acc_ff | i_instr[7:0];
						nxt_stat[`MCD_ST_Z] = (nxt_acc == 8'h00);
					end
					`MCD_LIT_AND: begin
						nxt_acc = acc_ff & i_instr[7:0];
						nxt_stat[`MCD_ST_Z] = (nxt_acc == 8'h00);
					end
					`MCD_LIT_XOR: begin
						nxt_acc = acc_ff ^ i_instr[7:0];
						nxt_stat[`MCD_ST_Z] = (nxt_acc == 8'h00);
					end
					`MCD_LIT_RETURN_WITH_LITERAL_OP: begin
						nxt_acc = i_instr[7:0];
						nxt_pc = stk_top;
						pop = 1'b1;
						nxt_redirect = 1'b1;
					end
					`MCD_LIT_SUB, `MCD_LIT_ADD: begin
						nxt_acc = alu.res;
						nxt_stat[`MCD_ST_Z]  = alu.z;
						nxt_stat[`MCD_ST_C]  = alu.c;
						nxt_stat[`MCD_ST_DC] = alu.dc;
					end
					`MCD_LIT_SEL: begin
						if (i_instr[7:4] == `MCD_SEL_PAGE) begin
							nxt_page = i_instr[1:0];
						end else if (i_instr[7:4] == `MCD_SEL_BANK) begin
							nxt_bank = {i_instr[1:0], bank_ff[5:0]};
						end
					end
					default: ;
				endcase
			end
		end else if (i_instr[11]) begin
			// Bit operations on any register
			case (i_instr[11:9])
				`MCD_BIT_CLR, `MCD_BIT_SET: begin
					res = rval;
					res[bidx] = i_instr[9];
					rw.wr = 1'b1;
				end
				default: begin
					nxt_skip = (rval[bidx] == i_instr[9]);
				end
			endcase
		end else if (i_instr[11:6] == 6'h00) begin
			// Miscellaneous and control-register group
			case (i_instr)
				`MCD_OP_NOP: ;
				`MCD_OP_DAA: begin
					res = acc_ff;
					if (res[3:0] > 4'h9) begin
						res = res + 8'h06;
					end
					if (res[7:4] > 4'h9 || stat_ff[`MCD_ST_C]) begin
						res = res + 8'h60;
						nxt_stat[`MCD_ST_C] = 1'b1;
					end
					nxt_acc = res;
				end
				`MCD_OP_SLEEP: begin
					nxt_wdc = 1'b1;
					nxt_sleep = 1'b1;
					nxt_stat[`MCD_ST_T] = 1'b1;
					nxt_stat[`MCD_ST_P] = 1'b0;
				end
				`MCD_OP_WDC: begin
					nxt_wdc = 1'b1;
					nxt_stat[`MCD_ST_T] = 1'b1;
					nxt_stat[`MCD_ST_P] = 1'b1;
				end
				`MCD_OP_EI: nxt_irq_en = 1'b1;
				`MCD_OP_DI: nxt_irq_en = 1'b0;
				`MCD_OP_RET, `MCD_OP_RETURN_FROM_IRQ_OP: begin
					nxt_pc = stk_top;
					pop = 1'b1;
					nxt_redirect = 1'b1;
					if (i_instr[0]) begin
						nxt_irq_en = 1'b1;
					end
				end
				default: begin
					// Only the defined control register range is reachable
					if (cra >= `MCD_CR_LO && cra <= `MCD_CR_HI) begin
						if (i_instr[4]) begin
							nxt_acc = cregs_ff[cra];
						end else begin
							crw = 1'b1;
						end
					end
				end
			endcase
		end else begin
			// Register operand group: ops selected by bits 10:7
			case (i_instr[10:7])
				4'h0: begin
					if (dst_r) begin
						res = acc_ff;
						rw.wr = 1'b1;
					end
				end
				4'h1: begin
					res = 8'h00;
					rw.wr = dst_r;
					nxt_acc = dst_r ? acc_ff : 8'h00;
					nxt_stat[`MCD_ST_Z] = 1'b1;
				end
				4'h2, 4'h7: begin
					res = alu.res;
					nxt_stat[`MCD_ST_Z]  = alu.z;
					nxt_stat[`MCD_ST_C]  = alu.c;
					nxt_stat[`MCD_ST_DC] = alu.dc;
				end
				4'h3: begin
					res = rval - 8'h01;
					nxt_stat[`MCD_ST_Z] = (res == 8'h00);
				end
				4'h4: res = acc_ff | rval;
				4'h5: res = acc_ff & rval;
				4'h6: res = acc_ff ^ rval;
				4'h8: res = rval;
				4'h9: res = ~rval;
				4'ha: res = rval + 8'h01;
				4'hb: begin
					res = rval - 8'h01;
					nxt_skip = (res == 8'h00);
				end
				4'hc: begin
					res = {stat_ff[`MCD_ST_C], rval[7:1]};
					nxt_stat[`MCD_ST_C] = rval[0];
				end
				4'hd: begin
					res = {rval[6:0], stat_ff[`MCD_ST_C]};
					nxt_stat[`MCD_ST_C] = rval[7];
				end
				4'he: res = {rval[3:0], rval[7:4]};
				4'hf: begin
					res = rval + 8'h01;
					nxt_skip = (res == 8'h00);
				end
				default: ;
			endcase
			// Logic, move and inc/dec ops update zero only
			if (i_instr[10:7] inside {4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'ha}) begin
				nxt_stat[`MCD_ST_Z] = (res == 8'h00);
			end
			if (i_instr[10:7] > 4'h1) begin
				if (dst_r) begin
					rw.wr = 1'b1;
				end else begin
					nxt_acc = res;
				end
			end
		end
		rw.data = res;
		// Special registers take register-file writes like any other
		if (rw.wr) begin
			case (ra)
				`MCD_ADDR_STAT: nxt_stat = res;
				`MCD_ADDR_BANK: nxt_bank = res;
				`MCD_ADDR_PAGE: nxt_page = res[1:0];
				default: ;
			endcase
		end
		// Writing program counter low byte redirects fetch
		if (rw.wr && ra == `MCD_ADDR_PC) begin
			nxt_pc = {pc_ff[11:10], page_ff, res};
			nxt_pc[9:8] = page_ff;
			nxt_redirect = 1'b1;
		end
		if (nxt_skip) begin
			nxt_redirect = 1'b1;
			nxt_pc = pc_ff + `MCD_PCW'(2);
		end
		if (!exec) begin
			push = 1'b0;
			pop  = 1'b0;
		end
	end

	// Sequencer: fetched word is discarded after any redirect
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			MCD_RUN: begin
				if (exec && nxt_sleep) begin
					nxt_state = MCD_SLEEP;
				end else if (exec && nxt_redirect) begin
					nxt_state = MCD_FLUSH;
				end
			end
			MCD_FLUSH: begin
				if (phase_ff) begin
					nxt_state = MCD_RUN;
				end
			end
			MCD_SLEEP: nxt_state = MCD_SLEEP;
			default:   nxt_state = MCD_RUN;
		endcase
	end

	// Phase and state
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			phase_ff <= 1'b0;
			state_ff <= MCD_RUN;
		end else begin
			phase_ff <= ~phase_ff;
			state_ff <= nxt_state;
		end
	end

	// Option bit is sampled on every clock after reset release
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			jsel_ff <= 1'b1;
		end else begin
			jsel_ff <= i_jump_cycle_select;
		end
	end

	// Architectural state commits at the end of each executed cycle
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			pc_ff     <= '0;
			acc_ff    <= 8'h00;
			stat_ff   <= 8'h18;
			bank_ff   <= 8'h00;
			page_ff   <= 2'b00;
			irq_en_ff <= 1'b0;
		end else if (exec) begin
			pc_ff     <= nxt_pc;
			acc_ff    <= nxt_acc;
			stat_ff   <= nxt_stat;
			bank_ff   <= nxt_bank;
			page_ff   <= nxt_page;
			irq_en_ff <= nxt_irq_en;
		end
	end

	// Data and control register arrays; no reset keeps them as RAM
	always_ff @(posedge i_clk_sys) begin
		if (exec && rw.wr) begin
			regs_ff[rw.addr] <= rw.data;
		end
		if (exec && crw) begin
			cregs_ff[cra] <= acc_ff;
		end
	end

	// Registered side outputs; write strobes and watchdog clear pulse for one clock, oscillator stop holds until reset
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			wdt_clr_ff  <= 1'b0;
			osc_stop_ff <= 1'b0;
			cr_wr_ff    <= 1'b0;
			cr_addr_ff  <= 4'h0;
			cr_wdata_ff <= 8'h00;
			io_wr_ff    <= '0;
		end else begin
			wdt_clr_ff  <= exec && nxt_wdc;
			osc_stop_ff <= (exec && nxt_sleep) || osc_stop_ff;
			cr_wr_ff    <= exec && crw;
			cr_addr_ff  <= cra;
			cr_wdata_ff <= acc_ff;
			io_wr_ff    <= '{wr: exec && rw.wr, addr: rw.addr, data: rw.data};
		end
	end

	assign o_pc       = pc_ff;
	assign o_phase    = phase_ff;
	assign o_acc      = acc_ff;
	assign o_status   = stat_ff;
	assign o_irq_en   = irq_en_ff;
	assign o_wdt_clr  = wdt_clr_ff;
	assign o_osc_stop = osc_stop_ff;
	assign o_cr_addr  = cr_addr_ff;
	assign o_cr_wdata = cr_wdata_ff;
	assign o_cr_wr    = cr_wr_ff;
	assign o_io_wr    = io_wr_ff;
	// i_io_rd reserved for external register reads (not used internally)
endmodule // mcd_core

/* design/mcd_cfg.svh */
/*
 * Constants for the instruction decode and execute core: opcode
 * fields, register addresses, status bit positions and timing.
 * Assumes it is included by its bare name from the design files.
 */
`ifndef MCD_CFG_SVH
`define MCD_CFG_SVH

`define MCD_IW          13
`define MCD_PCW         12
`define MCD_OSC_PER     2
`define MCD_STK_DEPTH   8
`define MCD_ADDR_PC     6'h02
`define MCD_ADDR_STAT   6'h03
`define MCD_ADDR_BANK   6'h04
`define MCD_ADDR_PAGE   6'h05
`define MCD_ST_C        0
`define MCD_ST_DC       1
`define MCD_ST_Z        2
`define MCD_ST_P        3
`define MCD_ST_T        4
`define MCD_OP_NOP      13'h0000
`define MCD_OP_DAA      13'h0001
`define MCD_OP_SLEEP    13'h0003
`define MCD_OP_WDC      13'h0004
`define MCD_OP_EI       13'h0010
`define MCD_OP_DI       13'h0011
`define MCD_OP_RET      13'h0012
`define MCD_OP_RETURN_FROM_IRQ_OP     13'h0013
`define MCD_OP_CLRA     13'h0080
`define MCD_BIT_CLR     3'h4
`define MCD_BIT_SET     3'h5
`define MCD_BIT_SKC     3'h6
`define MCD_BIT_SKS     3'h7
`define MCD_TOP_CALL    3'h4
`define MCD_TOP_JUMP    3'h5
`define MCD_LIT_MOV     4'h8
`define MCD_LIT_OR      4'h9
`define MCD_LIT_AND     4'ha
`define MCD_LIT_XOR     4'hb
`define MCD_LIT_RETURN_WITH_LITERAL_OP    4'hc
`define MCD_LIT_SUB     4'hd
`define MCD_LIT_SEL     4'he
`define MCD_LIT_ADD     4'hf
`define MCD_SEL_PAGE    4'h8
`define MCD_SEL_BANK    4'h9
`define MCD_CR_LO       4'h5
`define MCD_CR_HI       4'hf

`endif

/* design/mcd_pkg.sv */
/*
 * Types shared by the core and its helpers.
 * Assumes mcd_cfg.svh is on the include path.
 */
`include "mcd_cfg.svh"
package mcd_pkg;
	typedef enum logic [1:0] {
		MCD_RUN   = 2'b00,
		MCD_FLUSH = 2'b01,
		MCD_SLEEP = 2'b11
	} mcd_state_e;

	// Register file access requested by the execute stage
	typedef struct packed {
		logic       wr;
		logic [5:0] addr;
		logic [7:0] data;
	} mcd_regwr_s;

	// Result of the arithmetic unit with its flags
	typedef struct packed {
		logic [7:0] res;
		logic       z;
		logic       c;
		logic       dc;
	} mcd_alu_s;
endpackage

/* design/mcd_alu.sv */
/*
 * Eight-bit add/subtract with zero, carry and half-carry.
 * Assumes purely combinational use inside the execute stage.
 */
`timescale 1ns/1ps
module mcd_alu
	import mcd_pkg::*;
(
	input  wire logic [7:0] i_a,
	input  wire logic [7:0] i_b,
	input  wire logic       i_sub,
	output mcd_alu_s        o_res
);
	logic [8:0] sum;
	logic [4:0] half;
	logic [7:0] bop;

	// Subtract is a plus not b plus one; carry set means no borrow
	always_comb begin
		bop        = i_sub ? ~i_b : i_b;
		sum        = {1'b0, i_a} + {1'b0, bop} + {8'h00, i_sub};
		half       = {1'b0, i_a[3:0]} + {1'b0, bop[3:0]} + {4'h0, i_sub};
		o_res.res  = sum[7:0];
		o_res.z    = (sum[7:0] == 8'h00);
		o_res.c    = sum[8];
		o_res.dc   = half[4];
	end
endmodule // mcd_alu

/* design/mcd_stack.sv */
/*
 * Return address stack, circular, fixed depth.
 * Assumes push and pop never assert in the same cycle.
 */
`timescale 1ns/1ps
`include "mcd_cfg.svh"
module mcd_stack
	import mcd_pkg::*;
(
	input  wire logic                    i_clk_sys,
	input  wire logic                    i_rst,
	input  wire logic                    i_push,
	input  wire logic                    i_pop,
	input  wire logic [`MCD_PCW-1:0]     i_data,
	output logic      [`MCD_PCW-1:0]     o_top
);
	logic [`MCD_PCW-1:0] mem [`MCD_STK_DEPTH];
	logic [2:0]          sp_ff;

	// Overflow wraps silently, as on small cores without a trap
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			sp_ff <= 3'h0;
		end else if (i_push) begin
			sp_ff <= sp_ff + 3'h1;
		end else if (i_pop) begin
			sp_ff <= sp_ff - 3'h1;
		end
	end

	// Storage
	always_ff @(posedge i_clk_sys) begin
		if (i_push) begin
			mem[sp_ff] <= i_data;
		end
	end

	assign o_top = mem[sp_ff - 3'h1];
endmodule // mcd_stack

/* sim/mcd_core_monitor.sv */
/*
 * Checker for mcd_core: phase, pulse timing and flag updates.
 * Assumes it is bound to mcd_core and sees only its ports.
 */
`timescale 1ns/1ps
`include "mcd_cfg.svh"
module mcd_core_monitor
	import mcd_pkg::*;
(
	input  wire logic               i_clk_sys,
	input  wire logic               i_rst,
	input  wire logic [`MCD_IW-1:0] i_instr,
	input  wire logic               i_jump_cycle_select,
	input  wire logic [7:0]         i_io_rd,
	input  wire logic [`MCD_PCW-1:0] o_pc,
	input  wire logic               o_phase,
	input  wire mcd_regwr_s         o_io_wr,
	input  wire logic [7:0]         o_acc,
	input  wire logic [7:0]         o_status,
	input  wire logic               o_irq_en,
	input  wire logic               o_wdt_clr,
	input  wire logic               o_osc_stop,
	input  wire logic [3:0]         o_cr_addr,
	input  wire logic [7:0]         o_cr_wdata,
	input  wire logic               o_cr_wr
);
	logic [`MCD_IW-1:0] instr_q1_ff;

	// Word taken at the last edge, so a pulse one edge late has its cause
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			instr_q1_ff <= `MCD_OP_NOP;
		end else begin
			instr_q1_ff <= i_instr;
		end
	end

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);

	property p_phase_alt;
		!i_rst && !o_osc_stop ##1 !o_osc_stop |-> o_phase != $past(o_phase);
	endproperty
	a_phase_alt: assert property (p_phase_alt)
		else $error("phase did not alternate");
	property p_hold;
		!o_phase |=> $stable(o_pc) && $stable(o_acc) && $stable(o_status);
	endproperty
	a_hold: assert property (p_hold)
		else $error("state changed outside execute edge");
	property p_wdt_src;
		o_wdt_clr |-> instr_q1_ff inside {`MCD_OP_SLEEP, `MCD_OP_WDC};
	endproperty
	a_wdt_src: assert property (p_wdt_src)
		else $error("watchdog clear without its opcode");
	property p_wdt_flags;
		o_wdt_clr |-> o_status[`MCD_ST_T] &&
			(o_status[`MCD_ST_P] == (instr_q1_ff == `MCD_OP_WDC));
	endproperty
	a_wdt_flags: assert property (p_wdt_flags)
		else $error("time-out or power-down flag wrong");
	property p_osc_hold;
		o_osc_stop |=> o_osc_stop;
	endproperty
	a_osc_hold: assert property (p_osc_hold)
		else $error("oscillator stop released early");
	property p_cr_write;
		o_cr_wr |-> instr_q1_ff[12:4] == 9'h000 && o_cr_wdata == o_acc &&
			o_cr_addr == instr_q1_ff[3:0] && o_cr_addr >= `MCD_CR_LO;
	endproperty
	a_cr_write: assert property (p_cr_write)
		else $error("control register write mismatch");
	property p_irq_on;
		$rose(o_irq_en) |-> instr_q1_ff inside {`MCD_OP_EI, `MCD_OP_RETURN_FROM_IRQ_OP};
	endproperty
	a_irq_on: assert property (p_irq_on)
		else $error("interrupts enabled without cause");
	property p_irq_off;
		$fell(o_irq_en) |-> instr_q1_ff == `MCD_OP_DI;
	endproperty
	a_irq_off: assert property (p_irq_off)
		else $error("interrupts disabled without cause");
	property p_wr_pulse;
		o_io_wr.wr |=> !o_io_wr.wr;
	endproperty
	a_wr_pulse: assert property (p_wr_pulse)
		else $error("register write pulse too long");
	property p_mov_write;
		o_io_wr.wr && instr_q1_ff[12:6] == 7'h01 |->
			o_io_wr.addr == instr_q1_ff[5:0] && o_io_wr.data == o_acc;
	endproperty
	a_mov_write: assert property (p_mov_write)
		else $error("accumulator store went astray");
endmodule // mcd_core_monitor

bind mcd_core mcd_core_monitor i_mcd_core_monitor (
	.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_instr(i_instr),
	.i_jump_cycle_select(i_jump_cycle_select), .i_io_rd(i_io_rd),
	.o_pc(o_pc), .o_phase(o_phase), .o_io_wr(o_io_wr), .o_acc(o_acc),
	.o_status(o_status), .o_irq_en(o_irq_en), .o_wdt_clr(o_wdt_clr),
	.o_osc_stop(o_osc_stop), .o_cr_addr(o_cr_addr),
	.o_cr_wdata(o_cr_wdata), .o_cr_wr(o_cr_wr)
);

/* sim/mcd_prog_mem.sv */
/*
 * Program memory model facing the core's fetch port.
 * Assumes the bench loads words while reset is held.
 */
`timescale 1ns/1ps
`include "mcd_cfg.svh"
module mcd_prog_mem
	import mcd_pkg::*;
(
	input  wire logic [`MCD_PCW-1:0] i_pc,
	input  wire logic               i_clk_sys,
	output logic [`MCD_IW-1:0]      o_instr
);
	logic [`MCD_IW-1:0] mem_ff [0:(1<<`MCD_PCW)-1];

	// Unloaded places read as no-operation, never as unknown
	initial begin
		for (int a = 0; a < (1 << `MCD_PCW); a++) begin
			mem_ff[a] = `MCD_OP_NOP;
		end
	end

	// Whole word one clock after the address, like a synchronous ROM
	always_ff @(posedge i_clk_sys) begin
		o_instr <= mem_ff[i_pc];
	end
endmodule // mcd_prog_mem

/* sim/mcd_core_test.sv */
/*
 * Self-checking bench for mcd_core fed by a program memory model.
 * Assumes the checker file binds itself to the core.
 */
`timescale 1ns/1ps
`include "mcd_cfg.svh"
module mcd_core_test
	import mcd_pkg::*;
;
	typedef struct packed {
		logic [12:0] ins;
		logic [7:0]  acc;
		logic [7:0]  st;
		logic [7:0]  msk;
	} mcd_row_s;

	logic                i_clk_sys = 1'b0;
	logic                i_rst     = 1'b1;
	logic                jmp_sel   = 1'b1;
	logic [`MCD_IW-1:0]  instr;
	logic [`MCD_PCW-1:0] pc;
	logic                phase;
	logic [7:0]          acc;
	logic [7:0]          status;
	logic                osc_stop;
	logic [7:0]          st_keep;
	int                  miscompares = 0;
	int                  checked     = 0;
	// Straight-line words with accumulator and status after each
	mcd_row_s rows [25] = '{
		'{13'h185a, 8'h5a, 8'h18, 8'h1f}, '{13'h1fb0, 8'h0a, 8'h19, 8'h1f},
		'{13'h1d0a, 8'h00, 8'h04, 8'h04}, '{13'h1f08, 8'h08, 8'h18, 8'h1f},
		'{13'h1f08, 8'h10, 8'h1a, 8'h1f}, '{13'h1981, 8'h91, 8'h1a, 8'h1f},
		'{13'h1a0f, 8'h01, 8'h1a, 8'h1f}, '{13'h1b01, 8'h00, 8'h1e, 8'h1f},
		'{13'h18c3, 8'hc3, 8'h1e, 8'h1f}, '{13'h0050, 8'hc3, 8'h1e, 8'h1f},
		'{13'h0610, 8'h61, 8'h1f, 8'h1f}, '{13'h06d0, 8'h61, 8'h1f, 8'h1f},
		'{13'h0710, 8'h78, 8'h1f, 8'h1f}, '{13'h0510, 8'h88, 8'h1b, 8'h1f},
		'{13'h0410, 8'h87, 8'h1b, 8'h1f}, '{13'h0490, 8'h78, 8'h1b, 8'h1f},
		'{13'h0b90, 8'h78, 8'h1b, 8'h1f}, '{13'h0410, 8'hc7, 8'h1b, 8'h1f},
		'{13'h0810, 8'hc7, 8'h1b, 8'h1f}, '{13'h0410, 8'hc6, 8'h1b, 8'h1f},
		'{13'h0005, 8'hc6, 8'h1b, 8'h1f}, '{13'h0080, 8'h00, 8'h1f, 8'h1f},
		'{13'h0010, 8'h00, 8'h1f, 8'h1f}, '{13'h0011, 8'h00, 8'h1f, 8'h1f},
		'{13'h0004, 8'h00, 8'h1f, 8'h1f}
	};

	mcd_core i_mcd_core (
		.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_instr(instr),
		.i_jump_cycle_select(jmp_sel), .i_io_rd(8'h00), .o_pc(pc),
		.o_phase(phase), .o_io_wr(), .o_acc(acc), .o_status(status),
		.o_irq_en(), .o_wdt_clr(), .o_osc_stop(osc_stop), .o_cr_addr(),
		.o_cr_wdata(), .o_cr_wr()
	);
	mcd_prog_mem i_mcd_prog_mem (
		.i_pc(pc), .i_clk_sys(i_clk_sys), .o_instr(instr)
	);

	// 200 MHz system clock
	always #2.5 i_clk_sys = ~i_clk_sys;

	task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic put(input logic [11:0] a, input logic [12:0] w);
		i_mcd_prog_mem.mem_ff[a] = w;
	endtask

	// Wait for n second-phase edges, flush cycles included, then let their updates settle
	task automatic step(input int n);
		repeat (n) @(posedge i_clk_sys iff phase === 1'b1);
		#1;
	endtask

	task automatic report_and_stop();
		if (miscompares == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Run needs about 120 clocks; cut a hang well beyond that
	initial begin
		repeat (3000) @(posedge i_clk_sys);
		miscompares++;
		report_and_stop();
	end

	// Load program under reset, table first, then flow cases
	initial begin
		@(posedge i_clk_sys);
		foreach (rows[i])
			put(12'(i), rows[i].ins);
		put(12'h019, 13'h1440); put(12'h040, 13'h183c);
		put(12'h041, 13'h1e81); put(12'h042, 13'h1010);
		put(12'h410, 13'h1c77); put(12'h043, 13'h1450);
		put(12'h450, 13'h18ff); put(12'h451, 13'h0051);
		put(12'h452, 13'h0791); put(12'h453, 13'h1899);
		put(12'h454, 13'h1855); put(12'h455, 13'h05d1);
		put(12'h456, 13'h0411); put(12'h457, 13'h0c11);
		put(12'h458, 13'h1899); put(12'h459, 13'h1860);
		put(12'h45a, 13'h0042); put(12'h45b, 13'h1899);
		put(12'h560, 13'h0015); put(12'h561, 13'h1170);
		put(12'h570, 13'h0012); put(12'h562, `MCD_OP_SLEEP);
		repeat (3) @(posedge i_clk_sys);
		#1;
		chk({11'h000, phase}, 12'h000);
		chk({4'h0, status}, 12'h018);
		chk(pc, 12'h000);
		@(posedge i_clk_sys) i_rst <= 1'b0;
		for (int i = 0; i < 25; i++) begin
			step(1);
			chk({4'h0, acc}, {4'h0, rows[i].acc});
			chk({4'h0, status & rows[i].msk}, {4'h0, rows[i].st & rows[i].msk});
			chk(pc, 12'(i + 1));
		end
		// Jump in two cycles, then call across a page and return
		step(1);
		chk(pc, 12'h040);
		step(1);
		chk({4'h0, acc}, 12'h000);
		step(1);
		chk({4'h0, acc}, 12'h03c);
		step(2);
		chk(pc, 12'h410);
		step(2);
		chk({4'h0, acc}, 12'h077);
		chk(pc, 12'h043);
		@(posedge i_clk_sys) jmp_sel <= 1'b0;
		step(2);
		step(1);
		chk({4'h0, acc}, 12'h0ff);
		// Increment to zero skips, flags kept; decrement does not skip
		step(1);
		st_keep = status;
		step(1);
		chk(pc, 12'h454);
		chk({4'h0, status}, {4'h0, st_keep});
		step(1);
		chk({4'h0, acc}, 12'h000);
		step(1);
		chk({4'h0, acc}, 12'h055);
		step(1);
		chk(pc, 12'h456);
		step(1);
		chk({4'h0, acc}, 12'h0fe);
		// Bit test skip, then a store into the program counter
		step(1);
		chk(pc, 12'h459);
		step(2);
		chk({4'h0, acc}, 12'h060);
		step(1);
		chk({4'h0, pc[7:0]}, 12'h060);
		step(1);
		chk({4'h0, acc}, 12'h060);
		// Control register read, one-cycle call, plain return
		step(1);
		chk({4'h0, acc}, 12'h0c6);
		step(1);
		chk(pc, 12'h570);
		st_keep = status;
		step(1);
		chk(pc, 12'h562);
		chk({4'h0, status}, {4'h0, st_keep});
		step(1);
		chk(pc, 12'h562);
		step(1);
		repeat (2) @(posedge i_clk_sys);
		#1;
		chk({11'h000, osc_stop}, 12'h001);
		chk({10'h000, status[4:3]}, 12'h002);
		// Second reset in mid-run clears the sleep state
		@(posedge i_clk_sys) i_rst <= 1'b1;
		@(posedge i_clk_sys);
		#1;
		chk({11'h000, osc_stop}, 12'h000);
		chk(pc, 12'h000);
		@(posedge i_clk_sys) i_rst <= 1'b0;
		repeat (8) @(posedge i_clk_sys);
		report_and_stop();
	end
endmodule // mcd_core_test
